/* File: occ_config_regs.sv */
// How it works
// - Seven-bit frequency trim loads factory value per fuse frequency choice.
// - Read-only lock bit 7 of trim B blocks writes to both trims.
// - Lock bit is loaded at reset from the fuse trim lock.
// - Four-bit temperature slope trim loads factory value per fuse choice.
// - Low-power run-in-standby keeps that oscillator running always.
// - Low-power gate opens four cycles after request; start-up skipped with run-in-standby.
// - Select and start-up writes ignored while enabled or stable.
// - Start-up code picks 1k, 16k, 32k or 64k oscillator cycles.
// - External clock source skips the crystal start-up wait.
// - Select bit 2: zero crystal, one external clock on pin.
// - Crystal runs only when enabled: always with standby bit, else when requested.
// - Crystal output only on request, two oscillator cycles later.
// - Enable overrides both pins and freezes select and start-up.
// - Crystal standby and enable bits are write protected.
// - Crystal stable reads one only when stable and requested.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "occ_defines.svh"
module occ_config_regs
  import occ_pkg::*;
#(
  parameter logic [16:0] SU_1K      = `OCC_CRYSTAL_STARTUP_SEL_1K,
  parameter logic [16:0] SU_16K     = `OCC_CRYSTAL_STARTUP_SEL_16K,
  parameter logic [16:0] SU_32K     = `OCC_CRYSTAL_STARTUP_SEL_32K,
  parameter logic [16:0] SU_64K     = `OCC_CRYSTAL_STARTUP_SEL_64K,
  parameter logic [16:0] LP_STARTUP = `OCC_LP_STARTUP,
  parameter logic [6:0]  TRIM_16M   = `OCC_TRIM_16M,
  parameter logic [6:0]  TRIM_20M   = `OCC_TRIM_20M,
  parameter logic [3:0]  TEMP_16M   = `OCC_TEMP_16M,
  parameter logic [3:0]  TEMP_20M   = `OCC_TEMP_20M
)(
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        fuse_frequency_choice_i,
  input  wire logic        fuse_trim_lock_i,
  input  wire logic        lp_osc_req_i,
  input  wire logic        lp_osc_clk_i,
  input  wire logic        crystal_req_i,
  input  wire logic        crystal_pin_in_i,
  output logic      [6:0]  freq_trim_o,
  output logic      [3:0]  temp_slope_trim_o,
  output logic             trim_locked_o,
  output logic             lp_osc_run_o,
  output logic             lp_osc_gate_o,
  output logic             crystal_run_o,
  output logic             crystal_pin_override_o,
  output logic             crystal_ext_clock_o,
  output logic             crystal_gate_o,
  output logic             crystal_stable_o
);

  // --------------------------------------------------------------------
  // Oscillator tick synchronisers
  // --------------------------------------------------------------------
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync_prev;
  logic [1:0] tick;

  // Two flops per oscillator pin, then a rising-edge detector
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync1     <= 2'h0;
      sync2     <= 2'h0;
      sync_prev <= 2'h0;
    end else begin
      sync1     <= {crystal_pin_in_i, lp_osc_clk_i};
      sync2     <= sync1;
      sync_prev <= sync2;
    end
  end

  assign tick = sync2 & ~sync_prev;

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [6:0]  trim_a;
  logic [6:0]  next_trim_a;
  logic [3:0]  temp_trim;
  logic [3:0]  next_temp_trim;
  logic        lock;
  logic [7:0]  lp_ctrl;
  logic [7:0]  next_lp_ctrl;
  logic [7:0]  xosc_ctrl;
  logic [7:0]  next_xosc_ctrl;
  logic [4:0]  unlock_cnt;
  logic [4:0]  next_unlock_cnt;
  logic        wait_q;
  logic        next_wait_q;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        lp_run;
  logic        next_lp_run;
  logic        x_run;
  logic        next_x_run;
  logic        x_stable;
  logic        lp_stable;
  logic [7:0]  idx;
  logic        req;
  logic        wr_do;
  logic        unlocked;
  logic        prot_wr;
  logic [7:0]  wd;
  logic [16:0] x_startup;

  occ_osc_if #(.CW(17)) lp_if ();
  occ_osc_if #(.CW(17)) x_if ();

  assign idx      = avs_address_i[9:2];
  assign req      = avs_read_i | avs_write_i;
  assign wd       = avs_writedata_i[7:0];
  // A write lands at the edge where waitrequest is seen low
  assign wr_do    = avs_write_i && !wait_q && avs_byteenable_i[0];
  assign unlocked = unlock_cnt != 5'h00;
  assign prot_wr  = wr_do && unlocked;
  assign x_stable  = x_if.stable;
  assign lp_stable = lp_if.stable;

  // Crystal start-up length from select and start-up code
  always_comb begin
    case (xosc_ctrl[`OCC_X_CRYSTAL_STARTUP_SEL_MSB:`OCC_X_CRYSTAL_STARTUP_SEL_LSB])
      2'h0:    x_startup = SU_1K;
      2'h1:    x_startup = SU_16K;
      2'h2:    x_startup = SU_32K;
      2'h3:    x_startup = SU_64K;
      default: x_startup = SU_1K;
    endcase
    if (xosc_ctrl[`OCC_X_SEL]) begin
      x_startup = 17'h00000;
    end
  end

  // --------------------------------------------------------------------
  // Bus answer and register updates
  // --------------------------------------------------------------------
  // Next values for the bus slave and every register except lock and the run flags
  always_comb begin
    next_trim_a     = trim_a;
    next_temp_trim  = temp_trim;
    next_lp_ctrl    = lp_ctrl;
    next_xosc_ctrl  = xosc_ctrl;
    next_unlock_cnt = unlock_cnt;
    next_rdata      = rdata;
    next_wait_q     = 1'b1;
    // Waitrequest drops for one cycle, one cycle after the request
    if (req && wait_q) begin
      next_wait_q = 1'b0;
      next_rdata  = 32'h00000000;
      case (idx)
        `OCC_IDX_MAIN_STATUS: begin
          next_rdata[`OCC_ST_X_STABLE]  = x_stable;
          next_rdata[`OCC_ST_LP_STABLE] = lp_stable;
        end
        `OCC_IDX_TRIM_A:    next_rdata[6:0] = trim_a;
        `OCC_IDX_TRIM_B: begin
          next_rdata[`OCC_TRIM_B_LOCK]       = lock;
          next_rdata[`OCC_TRIM_B_TEMP_MSB:0] = temp_trim;
        end
        `OCC_IDX_LP_CTRL:   next_rdata[7:0] = lp_ctrl;
        `OCC_IDX_XOSC_CTRL: next_rdata[7:0] = xosc_ctrl;
        `OCC_IDX_UNLOCK:    next_rdata[`OCC_UNLOCK_OPEN] = unlocked;
        default:            next_rdata = 32'h00000000;
      endcase
    end
    // Unlock window counts down each cycle
    if (unlocked) begin
      next_unlock_cnt = unlock_cnt - 5'h01;
    end
    if (wr_do && idx == `OCC_IDX_UNLOCK && wd == `OCC_UNLOCK_KEY) begin
      next_unlock_cnt = `OCC_UNLOCK_CYCLES;
    end
    if (prot_wr) begin
      case (idx)
        `OCC_IDX_TRIM_A: begin
          if (!lock) begin
            next_trim_a = wd[`OCC_TRIM_A_MSB:0];
          end
          next_unlock_cnt = 5'h00;
        end
        `OCC_IDX_TRIM_B: begin
          if (!lock) begin
            next_temp_trim = wd[`OCC_TRIM_B_TEMP_MSB:0];
          end
          next_unlock_cnt = 5'h00;
        end
        `OCC_IDX_LP_CTRL: begin
          next_lp_ctrl = 8'h00;
          next_lp_ctrl[`OCC_LP_RUNSTBY] = wd[`OCC_LP_RUNSTBY];
          next_unlock_cnt = 5'h00;
        end
        `OCC_IDX_XOSC_CTRL: begin
          // Enable and standby bits only change inside the window
          next_xosc_ctrl[`OCC_X_ENABLE]  = wd[`OCC_X_ENABLE];
          next_xosc_ctrl[`OCC_X_RUNSTBY] = wd[`OCC_X_RUNSTBY];
          // Select and start-up freeze while enabled or stable
          if (!xosc_ctrl[`OCC_X_ENABLE] && !x_stable) begin
            next_xosc_ctrl[`OCC_X_SEL] = wd[`OCC_X_SEL];
            next_xosc_ctrl[`OCC_X_CRYSTAL_STARTUP_SEL_MSB:`OCC_X_CRYSTAL_STARTUP_SEL_LSB] =
              wd[`OCC_X_CRYSTAL_STARTUP_SEL_MSB:`OCC_X_CRYSTAL_STARTUP_SEL_LSB];
          end
          next_unlock_cnt = 5'h00;
        end
        default: next_unlock_cnt = next_unlock_cnt;
      endcase
    end
  end

  // Registers; trims and lock load from the fuses during reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      trim_a     <= fuse_frequency_choice_i ? TRIM_20M : TRIM_16M;
      temp_trim  <= fuse_frequency_choice_i ? TEMP_20M : TEMP_16M;
      lock       <= fuse_trim_lock_i;
      lp_ctrl    <= `OCC_LP_CTRL_RST;
      xosc_ctrl  <= `OCC_XOSC_CTRL_RST;
      unlock_cnt <= 5'h00;
      wait_q     <= 1'b1;
      rdata      <= 32'h00000000;
    end else begin
      trim_a     <= next_trim_a;
      temp_trim  <= next_temp_trim;
      lock       <= lock;
      lp_ctrl    <= next_lp_ctrl;
      xosc_ctrl  <= next_xosc_ctrl;
      unlock_cnt <= next_unlock_cnt;
      wait_q     <= next_wait_q;
      rdata      <= next_rdata;
    end
  end

  // --------------------------------------------------------------------
  // Oscillator run control
  // --------------------------------------------------------------------
  // Low-power runs forced or on request; crystal only when enabled
  always_comb begin
    next_lp_run = lp_ctrl[`OCC_LP_RUNSTBY] | lp_osc_req_i;
    next_x_run  = xosc_ctrl[`OCC_X_ENABLE] &
                  (xosc_ctrl[`OCC_X_RUNSTBY] | crystal_req_i);
  end

  // Run flags
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lp_run <= 1'b0;
      x_run  <= 1'b0;
    end else begin
      lp_run <= next_lp_run;
      x_run  <= next_x_run;
    end
  end

  // Low-power sequencer: start-up skipped when forced on
  assign lp_if.run         = lp_run;
  assign lp_if.req         = lp_osc_req_i;
  assign lp_if.tick        = tick[0];
  assign lp_if.startup_len = lp_ctrl[`OCC_LP_RUNSTBY] ? 17'h00000
                                                       : LP_STARTUP;
  assign lp_if.gate_delay  = `OCC_LP_GATE_CYCLES;

  // Crystal sequencer
  assign x_if.run          = x_run;
  assign x_if.req          = crystal_req_i;
  assign x_if.tick         = tick[1];
  assign x_if.startup_len  = x_startup;
  assign x_if.gate_delay   = `OCC_X_GATE_CYCLES;

  occ_osc_seq #(.CW(17)) u_lp_seq (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .osc       (lp_if.seq)
  );

  occ_osc_seq #(.CW(17)) u_x_seq (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .osc       (x_if.seq)
  );

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign avs_readdata_o         = rdata;
  assign avs_waitrequest_o      = wait_q;
  assign freq_trim_o            = trim_a;
  assign temp_slope_trim_o      = temp_trim;
  assign trim_locked_o          = lock;
  assign lp_osc_run_o           = lp_run;
  assign lp_osc_gate_o          = lp_if.gate_open;
  assign crystal_run_o          = x_run;
  assign crystal_pin_override_o = xosc_ctrl[`OCC_X_ENABLE];
  assign crystal_ext_clock_o    = xosc_ctrl[`OCC_X_SEL];
  assign crystal_gate_o         = x_if.gate_open;
  assign crystal_stable_o       = x_stable;

endmodule // occ_config_regs

/* File: occ_defines.svh */
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define OCC_IDX_MAIN_STATUS 8'h03
`define OCC_IDX_TRIM_A      8'h11
`define OCC_IDX_TRIM_B      8'h12
`define OCC_IDX_LP_CTRL     8'h18
`define OCC_IDX_XOSC_CTRL   8'h1c
`define OCC_IDX_UNLOCK      8'h1f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OCC_TRIM_A_MSB      6
`define OCC_TRIM_B_LOCK     7
`define OCC_TRIM_B_TEMP_MSB 3
`define OCC_LP_RUNSTBY      1
`define OCC_X_ENABLE        0
`define OCC_X_RUNSTBY       1
`define OCC_X_SEL           2
`define OCC_X_CRYSTAL_STARTUP_SEL_LSB      4
`define OCC_X_CRYSTAL_STARTUP_SEL_MSB      5
`define OCC_ST_LP_STABLE    5
`define OCC_ST_X_STABLE     6
`define OCC_UNLOCK_OPEN     0

// ----------------------------------------------------------------------
// Reset values and protection key
// ----------------------------------------------------------------------
`define OCC_LP_CTRL_RST     8'h00
`define OCC_XOSC_CTRL_RST   8'h00
`define OCC_UNLOCK_KEY      8'h5a
`define OCC_UNLOCK_CYCLES   5'h10

// ----------------------------------------------------------------------
// Oscillator cycle counts and factory trims
// ----------------------------------------------------------------------
`define OCC_LP_GATE_CYCLES  3'h4
`define OCC_X_GATE_CYCLES   3'h2
`define OCC_CRYSTAL_STARTUP_SEL_1K         17'h00400
`define OCC_CRYSTAL_STARTUP_SEL_16K        17'h04000
`define OCC_CRYSTAL_STARTUP_SEL_32K        17'h08000
`define OCC_CRYSTAL_STARTUP_SEL_64K        17'h10000
`define OCC_LP_STARTUP      17'h00040
`define OCC_TRIM_16M        7'h40
`define OCC_TRIM_20M        7'h40
`define OCC_TEMP_16M        4'h8
`define OCC_TEMP_20M        4'h8

`endif

/* File: occ_pkg.sv */
package occ_pkg;
  // Oscillator sequencer states
  typedef enum logic [2:0] {
    OCC_ST_OFF   = 3'b001,
    OCC_ST_START = 3'b010,
    OCC_ST_READY = 3'b100
  } occ_osc_state_type;
endpackage

/* File: occ_osc_if.sv */
`timescale 1ns/1ps
// Control and status between the register block and one sequencer
interface occ_osc_if #(parameter int CW = 17);
  logic          run;
  logic          req;
  logic          tick;
  logic [CW-1:0] startup_len;
  logic [2:0]    gate_delay;
  logic          gate_open;
  logic          stable;
  modport ctrl (output run, req, tick, startup_len, gate_delay,
                input gate_open, stable);
  modport seq  (input run, req, tick, startup_len, gate_delay,
                output gate_open, stable);
endinterface // occ_osc_if

/* File: occ_osc_seq.sv */
`timescale 1ns/1ps
module occ_osc_seq
  import occ_pkg::*;
#(
  parameter int CW = 17
)(
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  occ_osc_if.seq    osc
);

  // --------------------------------------------------------------------
  // Start-up wait and request gate
  // --------------------------------------------------------------------
  occ_osc_state_type state;
  occ_osc_state_type next_state;
  logic [CW-1:0]     count;
  logic [CW-1:0]     next_count;
  logic [2:0]        gcnt;
  logic [2:0]        next_gcnt;
  logic              gate;
  logic              next_gate;
  logic              stable;
  logic              next_stable;

  // Next state: count start-up ticks, then count gate ticks on request
  always_comb begin
    next_state = state;
    next_count = count;
    next_gcnt  = gcnt;
    next_gate  = gate;
    case (state)
      OCC_ST_OFF: begin
        next_count = '0;
        if (osc.run) begin
          next_state = OCC_ST_START;
        end
      end
      OCC_ST_START: begin
        if (!osc.run) begin
          next_state = OCC_ST_OFF;
        end else if (count >= osc.startup_len) begin
          next_state = OCC_ST_READY;
        end else if (osc.tick) begin
          next_count = count + 1'b1;
        end
      end
      OCC_ST_READY: begin
        if (!osc.run) begin
          next_state = OCC_ST_OFF;
        end
      end
      default: next_state = OCC_ST_OFF;
    endcase
    // Output only reaches users while requested and started
    if (!osc.req || !osc.run || state != OCC_ST_READY) begin
      next_gcnt = '0;
      next_gate = 1'b0;
    end else if (!gate && osc.tick) begin
      next_gcnt = gcnt + 3'h1;
      if (gcnt == osc.gate_delay - 3'h1) begin
        next_gate = 1'b1;
      end
    end
    // Stable shows only while the source is requested
    next_stable = (state == OCC_ST_READY) && osc.req && osc.run;
  end

  // Registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state  <= OCC_ST_OFF;
      count  <= '0;
      gcnt   <= '0;
      gate   <= 1'b0;
      stable <= 1'b0;
    end else begin
      state  <= next_state;
      count  <= next_count;
      gcnt   <= next_gcnt;
      gate   <= next_gate;
      stable <= next_stable;
    end
  end

  assign osc.gate_open = gate;
  assign osc.stable    = stable;

endmodule // occ_osc_seq

/* File: occ_xtal_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Crystal or clock source on the pins
// ----------------------------------------
module occ_xtal_model (
  input  wire logic run_i,
  output logic      pin_o
);
  // Swings only while powered; rests low otherwise
  initial begin
    pin_o = 1'b0;
    #2;
    forever begin
      #24;
      pin_o = run_i ? ~pin_o : 1'b0;
    end
  end
endmodule // occ_xtal_model

/* File: occ_config_regs_chk.sv */
`timescale 1ns/1ps
module occ_config_regs_chk (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic       lp_osc_req_i,
  input wire logic       crystal_req_i,
  input wire logic [6:0] freq_trim_o,
  input wire logic       trim_locked_o,
  input wire logic       lp_osc_run_o,
  input wire logic       lp_osc_gate_o,
  input wire logic       crystal_pin_override_o,
  input wire logic       crystal_ext_clock_o,
  input wire logic       crystal_gate_o,
  input wire logic       crystal_stable_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wait_one_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late answer");
  wait_pulse_a: assert property (!avs_waitrequest_o |=>
    avs_waitrequest_o) else $error("answer too long");
  lock_fixed_a: assert property (!$past(sys_rst_i) |->
    $stable(trim_locked_o)) else $error("lock moved");
  locked_trim_a: assert property (trim_locked_o && !$past(sys_rst_i)
    |-> $stable(freq_trim_o)) else $error("locked trim moved");
  lp_gate_off_a: assert property (!lp_osc_req_i [*3] |->
    !lp_osc_gate_o) else $error("lp gate without request");
  x_gate_off_a: assert property (!crystal_req_i [*3] |->
    !crystal_gate_o) else $error("crystal gate without request");
  x_stable_req_a: assert property (!crystal_req_i [*3] |->
    !crystal_stable_o) else $error("stable without request");
  sel_frozen_a: assert property (crystal_pin_override_o &&
    $past(crystal_pin_override_o) && !$past(sys_rst_i) |->
    $stable(crystal_ext_clock_o)) else $error("select moved");
  lp_run_req_a: assert property ($rose(lp_osc_req_i) |=>
    lp_osc_run_o) else $error("lp not run on request");
  cover property (crystal_stable_o);
  cover property (lp_osc_gate_o);
  cover property (trim_locked_o && avs_write_i);
endmodule // occ_config_regs_chk

bind occ_config_regs occ_config_regs_chk u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .lp_osc_req_i(lp_osc_req_i), .crystal_req_i(crystal_req_i),
  .freq_trim_o(freq_trim_o), .trim_locked_o(trim_locked_o),
  .lp_osc_run_o(lp_osc_run_o), .lp_osc_gate_o(lp_osc_gate_o),
  .crystal_pin_override_o(crystal_pin_override_o),
  .crystal_ext_clock_o(crystal_ext_clock_o),
  .crystal_gate_o(crystal_gate_o), .crystal_stable_o(crystal_stable_o));

/* File: test_occ_config_regs.sv */
`timescale 1ns/1ps
module test_occ_config_regs;
  logic        clk_sys_i, sys_rst_i, avs_read_i, avs_write_i;
  logic [9:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, d;
  logic        avs_waitrequest_o, fuse_frequency_choice_i, fuse_trim_lock_i;
  logic        lp_osc_req_i, lp_osc_clk_i, crystal_req_i, xpin;
  logic [6:0]  freq_trim_o;
  logic [3:0]  temp_slope_trim_o;
  logic        trim_locked_o, lp_osc_run_o, lp_osc_gate_o, crystal_run_o;
  logic        crystal_pin_override_o, crystal_ext_clock_o;
  logic        crystal_gate_o, crystal_stable_o;
  int          fail_count, compares, n;

  occ_config_regs #(.SU_1K(17'h4), .SU_16K(17'h8), .SU_32K(17'hc),
    .SU_64K(17'h10), .TRIM_20M(7'h2a)) DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .fuse_frequency_choice_i(fuse_frequency_choice_i),
    .fuse_trim_lock_i(fuse_trim_lock_i), .lp_osc_req_i(lp_osc_req_i),
    .lp_osc_clk_i(lp_osc_clk_i), .crystal_req_i(crystal_req_i),
    .crystal_pin_in_i(xpin), .freq_trim_o(freq_trim_o),
    .temp_slope_trim_o(temp_slope_trim_o), .trim_locked_o(trim_locked_o),
    .lp_osc_run_o(lp_osc_run_o), .lp_osc_gate_o(lp_osc_gate_o),
    .crystal_run_o(crystal_run_o),
    .crystal_pin_override_o(crystal_pin_override_o),
    .crystal_ext_clock_o(crystal_ext_clock_o),
    .crystal_gate_o(crystal_gate_o), .crystal_stable_o(crystal_stable_o));

  occ_xtal_model XM (.run_i(crystal_run_o), .pin_o(xpin));

  // ----------------------------------------
  // Clocks and watchdog
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Low-power oscillator, edges kept off the system edge
  initial begin
    lp_osc_clk_i = 1'b0;
    #2;
    forever #20 lp_osc_clk_i = ~lp_osc_clk_i;
  end
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, v};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // Unlock step, then the protected write
  task pw(input logic [9:0] a, input logic [7:0] v);
    bus(1'b1, 10'h7c, 8'h5a);
    bus(1'b1, a, v);
  endtask
  task rd(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(d, exp);
  endtask
  task automatic wait_for(ref logic s);
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (s !== 1'b1 && n < 2000);
  endtask
  task give_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset_vals;
    rd(10'h44, 32'h40);
    rd(10'h48, 32'h08);
    rd(10'h60, 32'h00);
    rd(10'h70, 32'h00);
    rd(10'h3c, 32'h00);
  endtask
  task t_protect;
    bus(1'b1, 10'h44, 8'h15);
    rd(10'h44, 32'h40);
    avs_byteenable_i <= 4'he;
    pw(10'h44, 8'h15);
    avs_byteenable_i <= 4'hf;
    rd(10'h44, 32'h40);
    pw(10'h44, 8'h15);
    rd(10'h44, 32'h15);
    chk(freq_trim_o, 32'h15);
    pw(10'h48, 8'h8c);
    rd(10'h48, 32'h0c);
    chk(temp_slope_trim_o, 32'hc);
  endtask
  task t_lp;
    lp_osc_req_i <= 1'b1;
    wait_for(lp_osc_gate_o);
    chk(lp_osc_gate_o, 1);
    chk(lp_osc_run_o, 1);
    lp_osc_req_i <= 1'b0;
    pw(10'h60, 8'h02);
    rd(10'h60, 32'h02);
    repeat (4) @(posedge clk_sys_i);
    chk(lp_osc_run_o, 1);
    chk(lp_osc_gate_o, 0);
    lp_osc_req_i <= 1'b1;
    wait_for(lp_osc_gate_o);
    chk(n >= 15 && n <= 26, 1);
    lp_osc_req_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk(lp_osc_gate_o, 0);
  endtask
  task t_xtal_fast;
    bus(1'b1, 10'h70, 8'h03);
    rd(10'h70, 32'h00);
    chk(crystal_pin_override_o, 0);
    pw(10'h70, 8'h07);
    repeat (4) @(posedge clk_sys_i);
    chk(crystal_pin_override_o, 1);
    chk(crystal_ext_clock_o, 1);
    chk(crystal_run_o, 1);
    chk(crystal_stable_o, 0);
    pw(10'h70, 8'h33);
    rd(10'h70, 32'h07);
    repeat (40) @(posedge clk_sys_i);
    crystal_req_i <= 1'b1;
    wait_for(crystal_gate_o);
    chk(n >= 4 && n <= 21, 1);
    rd(10'h0c, 32'h40);
    crystal_req_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk(crystal_gate_o, 0);
    chk(crystal_run_o, 1);
    pw(10'h70, 8'h00);
  endtask
  task t_crystal_startup_sel;
    int prev;
    logic [7:0] v;
    prev = 0;
    for (int c = 0; c < 5; c++) begin
      v = (c < 4) ? {2'b0, 2'(c), 4'h1} : 8'h05;
      pw(10'h70, v);
      rd(10'h70, {24'h0, v});
      crystal_req_i <= 1'b1;
      wait_for(crystal_stable_o);
      chk(crystal_stable_o, 1);
      if (c < 4)
        chk(n > prev + 20, 1);
      else
        chk(n < 20, 1);
      prev = n;
      crystal_req_i <= 1'b0;
      chk(crystal_run_o, 1);
      pw(10'h70, 8'h00);
      do bus(1'b0, 10'h0c, 8'h00); while (d[6] !== 1'b0);
      chk(crystal_run_o, 0);
    end
  endtask
  task t_lock;
    fuse_trim_lock_i <= 1'b1;
    fuse_frequency_choice_i <= 1'b1;
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk(trim_locked_o, 1);
    chk(freq_trim_o, 32'h2a);
    chk(temp_slope_trim_o, 32'h8);
    pw(10'h44, 8'h11);
    rd(10'h44, 32'h2a);
    pw(10'h48, 8'h05);
    rd(10'h48, 32'h88);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    compares = 0;
    sys_rst_i = 1'b1;
    avs_address_i = 10'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    fuse_frequency_choice_i = 1'b0;
    fuse_trim_lock_i = 1'b0;
    lp_osc_req_i = 1'b0;
    crystal_req_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset_vals();
    t_protect();
    t_lp();
    t_xtal_fast();
    t_crystal_startup_sel();
    t_lock();
    give_verdict();
  end
endmodule // test_occ_config_regs
